/* File: common/mpt_pkg.sv */
package mpt_pkg;
   localparam int CNT_W = 16;
   localparam int NCH   = 4;
   localparam int NPAIR = 3;
   localparam int NEV   = 6;
   localparam int DT_W  = 8;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_PRESC  = 8'h04;
   localparam logic [7:0] OFS_RELOAD = 8'h08;
   localparam logic [7:0] OFS_COUNT  = 8'h0C;
   localparam logic [7:0] OFS_CHMODE = 8'h10;
   localparam logic [7:0] OFS_DEAD   = 8'h14;
   localparam logic [7:0] OFS_CCR0   = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h28;
   localparam logic [7:0] OFS_MASK   = 8'h2C;
   localparam logic [7:0] OFS_DMAEN  = 8'h30;

   // control field positions
   localparam int CTRL_EN     = 0;
   localparam int CTRL_MODE   = 1;
   localparam int CTRL_OPM    = 3;
   localparam int CTRL_FREEZE = 4;
   localparam int CTRL_BASIC  = 5;
   localparam int CTRL_TSTART = 6;
   localparam int CTRL_EXTCLK = 7;
   localparam int CTRL_OE     = 8;
   localparam int CTRL_W      = 9;
   localparam int CHM_W       = 3;

   // status / mask / dma enable bit positions
   localparam int EV_UPD  = 0;
   localparam int EV_CH0  = 1;
   localparam int EV_TRIG = 5;

   // values after reset
   localparam logic [CTRL_W-1:0] RST_CTRL   = 9'h000;
   localparam logic [CNT_W-1:0]  RST_PRESC  = 16'h0000;
   localparam logic [CNT_W-1:0]  RST_RELOAD = 16'hFFFF;
   localparam logic [CNT_W-1:0]  RST_COUNT  = 16'h0000;
   localparam logic [DT_W-1:0]   RST_DEAD   = 8'h00;
   localparam logic [NEV-1:0]    RST_EV     = 6'h00;

   typedef enum logic [1:0] {CNT_UP, CNT_DOWN, CNT_CENTER, CNT_RSVD} mpt_cntmode_t;
   typedef enum logic [2:0] {
      CHM_OFF, CHM_CAP_RISE, CHM_CAP_FALL, CHM_CMP_TOGGLE, CHM_PWM,
      CHM_R5, CHM_R6, CHM_R7
   } mpt_chmode_t;
endpackage

/* File: hdl/mpt_channel.sv */
`timescale 1ns/100ps
module mpt_channel
   import mpt_pkg::*;
(
   // clock and reset
   input  wire logic                      clk_in,
   input  wire logic                      resetn_in,
   // configuration and counter
   input  wire mpt_pkg::mpt_chmode_t      mode_in,
   input  wire logic [mpt_pkg::CNT_W-1:0] count_in,
   input  wire logic                      tick_in,
   input  wire logic                      cap_level_in,
   // software write of the compare value
   input  wire logic                      wr_in,
   input  wire logic [mpt_pkg::CNT_W-1:0] wdata_in,
   // results
   output logic      [mpt_pkg::CNT_W-1:0] ccr_out,
   output logic                           ref_out,
   output logic                           event_out
);
   import mpt_pkg::*;

   logic [CNT_W-1:0] ccr_ff, nxt_ccr;
   logic             ref_ff, nxt_ref;
   logic             ev_ff, nxt_ev;
   logic             lvl_prev_ff, nxt_lvl_prev;
   logic             rise, fall, cap_hit, cmp_hit;

   always_comb begin
      rise         = cap_level_in & ~lvl_prev_ff;
      fall         = ~cap_level_in & lvl_prev_ff;
      cap_hit      = ((mode_in == CHM_CAP_RISE) & rise) |
                     ((mode_in == CHM_CAP_FALL) & fall);
      cmp_hit      = tick_in & (count_in == ccr_ff) &
                     ((mode_in == CHM_CMP_TOGGLE) | (mode_in == CHM_PWM));
      nxt_lvl_prev = cap_level_in;
      nxt_ccr      = ccr_ff;
      // capture beats a software write in the same cycle
      if (wr_in) begin
         nxt_ccr = wdata_in;
      end
      if (cap_hit) begin
         nxt_ccr = count_in;
      end
      nxt_ev = cap_hit | cmp_hit;
      case (mode_in)
         CHM_PWM: begin
            // reference below compare: 0 gives never active, above reload always active
            nxt_ref = (count_in < ccr_ff);
         end
         CHM_CMP_TOGGLE: begin
            nxt_ref = cmp_hit ? ~ref_ff : ref_ff;
         end
         default: begin
            nxt_ref = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ccr_ff      <= RST_COUNT;
         ref_ff      <= 1'b0;
         ev_ff       <= 1'b0;
         lvl_prev_ff <= 1'b0;
      end else begin
         ccr_ff      <= nxt_ccr;
         ref_ff      <= nxt_ref;
         ev_ff       <= nxt_ev;
         lvl_prev_ff <= nxt_lvl_prev;
      end
   end

   assign ccr_out   = ccr_ff;
   assign ref_out   = ref_ff;
   assign event_out = ev_ff;

   chk_capture_latch: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (mode_in == CHM_CAP_RISE) && cap_level_in && !lvl_prev_ff
         |=> (ccr_ff == $past(count_in)) && event_out)
      else $error("capture did not latch count or flag");

   chk_pwm_level: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (mode_in == CHM_PWM) && $stable(mode_in) && !wr_in
         |=> ref_out == ($past(count_in) < $past(ccr_ff)))
      else $error("pwm reference does not follow compare");
endmodule

/* File: hdl/mpt_timer.sv */
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
// Operation
// - 16-bit auto-reload counter: up, down, up/down
// - 16-bit prescaler divides clock by integer
// - four channels: capture, compare, pwm, one-pulse
// - pwm edge-aligned or center-aligned via up/down
// - three complementary pairs with programmable dead time
// - duty from always off to always on
// - debug halt with freeze holds the counter
// - timer raises its own dma requests
// - trigger output and peer trigger input chaining
// - basic mode: up only, no channels, trigger
module mpt_timer
   import mpt_pkg::*;
(
   // clock and reset
   input  wire logic                        clk_in,
   input  wire logic                        resetn_in,
   // register port
   input  wire logic [7:0]                  addr_in,
   input  wire logic [31:0]                 wdata_in,
   input  wire logic                        wr_in,
   input  wire logic                        rd_in,
   output logic      [31:0]                 rdata_out,
   // channel pins
   input  wire logic [mpt_pkg::NCH-1:0]     cap_in,
   output logic      [mpt_pkg::NCH-1:0]     pwm_out,
   output logic      [mpt_pkg::NPAIR-1:0]   pair_hi_out,
   output logic      [mpt_pkg::NPAIR-1:0]   pair_lo_out,
   // peer timers, debug, dma, interrupt
   input  wire logic                        trig_in,
   output logic                             trig_out,
   input  wire logic                        halt_in,
   output logic      [mpt_pkg::NCH:0]       dma_req_out,
   output logic                             irq_out
);
   import mpt_pkg::*;

   logic [CTRL_W-1:0]      ctrl_ff, nxt_ctrl;
   logic [CNT_W-1:0]       psc_ff, nxt_psc;
   logic [CNT_W-1:0]       reload_ff, nxt_reload;
   logic [CNT_W-1:0]       cnt_ff, nxt_cnt;
   logic [CNT_W-1:0]       pcnt_ff, nxt_pcnt;
   logic                   down_ff, nxt_down;
   logic [NCH*CHM_W-1:0]   chmode_ff, nxt_chmode;
   logic [DT_W-1:0]        dead_ff, nxt_dead;
   logic [NEV-1:0]         status_ff, nxt_status;
   logic [NEV-1:0]         mask_ff, nxt_mask;
   logic [NCH:0]           dmaen_ff, nxt_dmaen;
   logic [NCH:0]           dma_ff, nxt_dma;
   logic                   trig_ff, nxt_trig;
   logic [31:0]            rdata_ff, nxt_rdata;
   logic [NCH-1:0]         s1_ff, s2_ff, s3_ff, lvl_ff;
   logic [NCH-1:0]         nxt_lvl;

   logic                   frozen, tick, upd, basic, pwr;
   mpt_cntmode_t           cmode;
   logic [NCH-1:0]         ch_ref, ch_ev, ch_wr;
   logic [CNT_W-1:0]       ccr [NCH];
   logic [NEV-1:0]         events;

   // capture pins: three stages, level taken once the last two agree
   always_comb begin
      nxt_lvl = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & lvl_ff);
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s1_ff  <= '0;
         s2_ff  <= '0;
         s3_ff  <= '0;
         lvl_ff <= '0;
      end else begin
         s1_ff  <= cap_in;
         s2_ff  <= s1_ff;
         s3_ff  <= s2_ff;
         lvl_ff <= nxt_lvl;
      end
   end

   // counter, prescaler, control and registers
   always_comb begin
      basic      = ctrl_ff[CTRL_BASIC];
      cmode      = basic ? CNT_UP : mpt_cntmode_t'(ctrl_ff[CTRL_MODE +: 2]);
      frozen     = halt_in & ctrl_ff[CTRL_FREEZE];
      pwr        = ctrl_ff[CTRL_EN] & ~frozen;
      tick       = pwr & (ctrl_ff[CTRL_EXTCLK] ? trig_in : (pcnt_ff == psc_ff));
      nxt_pcnt   = pcnt_ff;
      if (pwr && !ctrl_ff[CTRL_EXTCLK]) begin
         nxt_pcnt = (pcnt_ff == psc_ff) ? '0 : pcnt_ff + 16'h0001;
      end
      nxt_cnt    = cnt_ff;
      nxt_down   = down_ff;
      upd        = 1'b0;
      if (tick) begin
         case (cmode)
            CNT_UP: begin
               if (cnt_ff == reload_ff) begin
                  nxt_cnt = '0;
                  upd     = 1'b1;
               end else begin
                  nxt_cnt = cnt_ff + 16'h0001;
               end
            end
            CNT_DOWN: begin
               if (cnt_ff == '0) begin
                  nxt_cnt = reload_ff;
                  upd     = 1'b1;
               end else begin
                  nxt_cnt = cnt_ff - 16'h0001;
               end
            end
            CNT_CENTER: begin
               // turn at both ends; update at each turn
               if (!down_ff && cnt_ff >= reload_ff) begin
                  nxt_down = 1'b1;
                  nxt_cnt  = (reload_ff == '0) ? '0 : reload_ff - 16'h0001;
                  upd      = 1'b1;
               end else if (down_ff && cnt_ff == '0) begin
                  nxt_down = 1'b0;
                  nxt_cnt  = (reload_ff == '0) ? '0 : 16'h0001;
                  upd      = 1'b1;
               end else begin
                  nxt_cnt  = down_ff ? cnt_ff - 16'h0001 : cnt_ff + 16'h0001;
               end
            end
            default: begin
               nxt_cnt = cnt_ff;
            end
         endcase
      end

      nxt_ctrl   = ctrl_ff;
      nxt_psc    = psc_ff;
      nxt_reload = reload_ff;
      nxt_chmode = chmode_ff;
      nxt_dead   = dead_ff;
      nxt_mask   = mask_ff;
      nxt_dmaen  = dmaen_ff;
      ch_wr      = '0;
      if (wr_in) begin
         case (addr_in)
            OFS_CTRL:   nxt_ctrl   = wdata_in[CTRL_W-1:0];
            OFS_PRESC:  nxt_psc    = wdata_in[CNT_W-1:0];
            OFS_RELOAD: nxt_reload = wdata_in[CNT_W-1:0];
            OFS_COUNT: begin
               nxt_cnt  = wdata_in[CNT_W-1:0];
               nxt_pcnt = '0;
            end
            OFS_CHMODE: nxt_chmode = wdata_in[NCH*CHM_W-1:0];
            OFS_DEAD:   nxt_dead   = wdata_in[DT_W-1:0];
            OFS_MASK:   nxt_mask   = wdata_in[NEV-1:0];
            OFS_DMAEN:  nxt_dmaen  = wdata_in[NCH:0];
            default: begin
               for (int i = 0; i < NCH; i++) begin
                  if (addr_in == OFS_CCR0 + 8'(4 * i)) begin
                     ch_wr[i] = 1'b1;
                  end
               end
            end
         endcase
      end
      // hardware start/stop applied after the software write
      if (ctrl_ff[CTRL_TSTART] && trig_in) begin
         nxt_ctrl[CTRL_EN] = 1'b1;
      end
      if (upd && ctrl_ff[CTRL_OPM]) begin
         nxt_ctrl[CTRL_EN] = 1'b0;
      end

      events     = {trig_in, ch_ev & {NCH{~basic}}, upd};
      // a new event wins over the clear-on-read
      nxt_status = ((rd_in && addr_in == OFS_STATUS) ? RST_EV : status_ff) | events;
      nxt_dma    = events[NCH:0] & dmaen_ff;
      nxt_trig   = upd;

      nxt_rdata  = '0;
      if (rd_in) begin
         case (addr_in)
            OFS_CTRL:   nxt_rdata[CTRL_W-1:0]    = ctrl_ff;
            OFS_PRESC:  nxt_rdata[CNT_W-1:0]     = psc_ff;
            OFS_RELOAD: nxt_rdata[CNT_W-1:0]     = reload_ff;
            OFS_COUNT:  nxt_rdata[CNT_W-1:0]     = cnt_ff;
            OFS_CHMODE: nxt_rdata[NCH*CHM_W-1:0] = chmode_ff;
            OFS_DEAD:   nxt_rdata[DT_W-1:0]      = dead_ff;
            OFS_STATUS: nxt_rdata[NEV-1:0]       = status_ff;
            OFS_MASK:   nxt_rdata[NEV-1:0]       = mask_ff;
            OFS_DMAEN:  nxt_rdata[NCH:0]         = dmaen_ff;
            default: begin
               for (int i = 0; i < NCH; i++) begin
                  if (addr_in == OFS_CCR0 + 8'(4 * i)) begin
                     nxt_rdata[CNT_W-1:0] = ccr[i];
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ctrl_ff   <= RST_CTRL;
         psc_ff    <= RST_PRESC;
         reload_ff <= RST_RELOAD;
         cnt_ff    <= RST_COUNT;
         pcnt_ff   <= RST_COUNT;
         down_ff   <= 1'b0;
         chmode_ff <= '0;
         dead_ff   <= RST_DEAD;
         status_ff <= RST_EV;
         mask_ff   <= RST_EV;
         dmaen_ff  <= '0;
         dma_ff    <= '0;
         trig_ff   <= 1'b0;
         rdata_ff  <= '0;
      end else begin
         ctrl_ff   <= nxt_ctrl;
         psc_ff    <= nxt_psc;
         reload_ff <= nxt_reload;
         cnt_ff    <= nxt_cnt;
         pcnt_ff   <= nxt_pcnt;
         down_ff   <= nxt_down;
         chmode_ff <= nxt_chmode;
         dead_ff   <= nxt_dead;
         status_ff <= nxt_status;
         mask_ff   <= nxt_mask;
         dmaen_ff  <= nxt_dmaen;
         dma_ff    <= nxt_dma;
         trig_ff   <= nxt_trig;
         rdata_ff  <= nxt_rdata;
      end
   end

   // channels; basic mode forces them off
   for (genvar g = 0; g < NCH; g++) begin : g_ch
      mpt_channel u_ch (
         .clk_in       (clk_in),
         .resetn_in    (resetn_in),
         .mode_in      (basic ? CHM_OFF : mpt_chmode_t'(chmode_ff[g*CHM_W +: CHM_W])),
         .count_in     (cnt_ff),
         .tick_in      (tick),
         .cap_level_in (lvl_ff[g]),
         .wr_in        (ch_wr[g]),
         .wdata_in     (wdata_in[CNT_W-1:0]),
         .ccr_out      (ccr[g]),
         .ref_out      (ch_ref[g]),
         .event_out    (ch_ev[g])
      );
   end

   // complementary pairs: both sides low for the dead time plus one cycle after each edge
   for (genvar p = 0; p < NPAIR; p++) begin : g_pair
      logic            hi_ff, lo_ff, last_ff, nxt_hi, nxt_lo, nxt_last;
      logic [DT_W-1:0] dt_ff, nxt_dt;
      always_comb begin
         nxt_last = ch_ref[p];
         nxt_dt   = dt_ff;
         nxt_hi   = hi_ff;
         nxt_lo   = lo_ff;
         if (ch_ref[p] != last_ff) begin
            nxt_hi = 1'b0;
            nxt_lo = 1'b0;
            nxt_dt = dead_ff;
         end else if (dt_ff != '0) begin
            nxt_dt = dt_ff - 8'h01;
         end else begin
            nxt_hi = ch_ref[p];
            nxt_lo = ~ch_ref[p];
         end
         if (!ctrl_ff[CTRL_OE]) begin
            nxt_hi = 1'b0;
            nxt_lo = 1'b0;
         end
      end
      always_ff @(posedge clk_in or negedge resetn_in) begin
         if (!resetn_in) begin
            hi_ff   <= 1'b0;
            lo_ff   <= 1'b0;
            last_ff <= 1'b0;
            dt_ff   <= RST_DEAD;
         end else begin
            hi_ff   <= nxt_hi;
            lo_ff   <= nxt_lo;
            last_ff <= nxt_last;
            dt_ff   <= nxt_dt;
         end
      end
      assign pair_hi_out[p] = hi_ff;
      assign pair_lo_out[p] = lo_ff;
      chk_dead_gap: assert property (@(posedge clk_in) disable iff (!resetn_in)
         $rose(hi_ff) |-> !$past(lo_ff, 1) && (dead_ff == '0 || !$past(lo_ff, 2)))
         else $error("complement rose without dead gap");
   end

   assign pwm_out     = ch_ref & {NCH{ctrl_ff[CTRL_OE]}};
   assign rdata_out   = rdata_ff;
   assign trig_out    = trig_ff;
   assign dma_req_out = dma_ff;
   assign irq_out     = |(status_ff & mask_ff);

   chk_up_wrap: assert property (@(posedge clk_in) disable iff (!resetn_in)
      tick && cmode == CNT_UP && cnt_ff == reload_ff && !wr_in
         |=> cnt_ff == '0 ##0 trig_out ##0 status_ff[EV_UPD])
      else $error("up count did not wrap with update");

   chk_down_reload: assert property (@(posedge clk_in) disable iff (!resetn_in)
      tick && cmode == CNT_DOWN && cnt_ff == '0 && !wr_in
         |=> cnt_ff == $past(reload_ff) && trig_out)
      else $error("down count did not reload");

   chk_freeze_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
      halt_in && ctrl_ff[CTRL_FREEZE] && !wr_in |=> $stable(cnt_ff))
      else $error("counter moved during frozen halt");

   chk_prescale_tick: assert property (@(posedge clk_in) disable iff (!resetn_in)
      pwr && !ctrl_ff[CTRL_EXTCLK] && psc_ff == 16'h0003 && pcnt_ff == '0 && !wr_in
         ##1 (pwr && !wr_in) [*3] |-> tick && !$past(tick))
      else $error("prescaler divide count wrong");

   chk_dma_pace: assert property (@(posedge clk_in) disable iff (!resetn_in)
      dma_req_out[0] |-> $past(upd) && $past(dmaen_ff[0]))
      else $error("update dma request without update");

   chk_basic_up: assert property (@(posedge clk_in) disable iff (!resetn_in)
      basic && tick && !wr_in && cnt_ff != reload_ff
         |=> cnt_ff == $past(cnt_ff) + 16'h0001 && !$rose(status_ff[EV_CH0]))
      else $error("basic mode not counting up");

   chk_ext_chain: assert property (@(posedge clk_in) disable iff (!resetn_in)
      ctrl_ff[CTRL_EN] && ctrl_ff[CTRL_EXTCLK] && !frozen && !trig_in && !wr_in
         |=> $stable(cnt_ff))
      else $error("chained counter moved without trigger");
endmodule

/* File: verification/mpt_far_side.sv */
`timescale 1ns/100ps
// capture sources and a peer timer seen from the timer's pins
module mpt_far_side
   import mpt_pkg::*;
#(
   parameter int PEER_PERIOD = 7
)
(
   // clock and reset
   input  wire logic                    clk_in,
   input  wire logic                    resetn_in,
   // bench controls
   input  wire logic [mpt_pkg::NCH-1:0] cap_lvl_in,
   input  wire logic                    peer_run_in,
   // towards the timer
   output logic      [mpt_pkg::NCH-1:0] cap_out,
   output logic                         trig_out
);
   int unsigned div_ff;

   // pins move only right after an edge, like a real driver on this clock
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cap_out <= '0;
         trig_out <= 1'b0;
         div_ff <= 0;
      end else begin
         cap_out <= cap_lvl_in;
         // one-cycle peer update pulse per period while running
         trig_out <= peer_run_in && (div_ff == PEER_PERIOD - 1);
         div_ff <= (!peer_run_in || div_ff == PEER_PERIOD - 1) ? 0 : div_ff + 1;
      end
   end
endmodule

/* File: verification/tb.sv */
`timescale 1ns/100ps
module tb;
   import mpt_pkg::*;

   logic        clk_in, resetn_in, wr_in, rd_in, halt_in, trig_in, trig_out, irq_out, peer_run;
   logic [7:0]  addr_in;
   logic [31:0] wdata_in, rdata_out, d, d2;
   logic [3:0]  cap_in, cap_lvl, pwm_out;
   logic [2:0]  pair_hi_out, pair_lo_out;
   logic [4:0]  dma_req_out;
   wire  [7:0]  ev = {pair_lo_out[0], pair_hi_out[0], trig_out, dma_req_out};
   int          err_count, n_compared, n, p;
   logic [7:0]  ra[5] = '{OFS_CTRL, OFS_PRESC, OFS_RELOAD, OFS_COUNT, 8'h3C};
   logic [31:0] rv[5] = '{32'h0, 32'h0, 32'hFFFF, 32'h0, 32'h0};
   logic [31:0] pp[4] = '{32'h0, 32'h3, 32'h1, 32'h1};
   logic [31:0] cm[4] = '{32'h1, 32'h1, 32'h3, 32'h5};
   logic [31:0] gp[4] = '{32'h4, 32'h10, 32'h8, 32'h6};
   logic [31:0] cc[4] = '{32'h11, 32'h1, 32'h23, 32'h3};
   logic [31:0] dd[4] = '{32'h0, 32'h1, 32'h1, 32'hFFFF};

   mpt_timer i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .cap_in(cap_in), .pwm_out(pwm_out), .pair_hi_out(pair_hi_out),
      .pair_lo_out(pair_lo_out), .trig_in(trig_in), .trig_out(trig_out),
      .halt_in(halt_in), .dma_req_out(dma_req_out), .irq_out(irq_out));
   mpt_far_side i_far (.clk_in(clk_in), .resetn_in(resetn_in), .cap_lvl_in(cap_lvl),
      .peer_run_in(peer_run), .cap_out(cap_in), .trig_out(trig_in));

   always #2.5 clk_in = ~clk_in;

   task automatic test_done();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= v;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 v = rdata_out;
   endtask

   // two back-to-back count reads, one cycle apart
   task automatic rd2(output logic [31:0] v1, output logic [31:0] v2);
      @(posedge clk_in);
      addr_in <= OFS_COUNT;
      rd_in <= 1'b1;
      @(posedge clk_in);
      #1 v1 = rdata_out;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 v2 = rdata_out;
   endtask

   // counts edges until ev[b] shows lvl; a hang ends the run
   task automatic wait_ev(input int b, input logic lvl, output int k);
      k = 0;
      do begin
         @(posedge clk_in);
         #1 k++;
      end while (ev[b] !== lvl && k < 500);
      if (k >= 500) begin
         err_count++;
         $display("mismatch event %0d expected %b seen timeout", b, lvl);
         test_done();
      end
   endtask

   // the two sides of a pair must never be on together
   always @(posedge clk_in) begin
      #1;
      if (resetn_in && (pair_hi_out & pair_lo_out) !== 3'h0) begin
         err_count++;
         $display("mismatch pair overlap expected 0 seen %h", pair_hi_out & pair_lo_out);
      end
   end

   initial begin
      clk_in = 0; resetn_in = 0; addr_in = '0; wdata_in = '0; wr_in = 0; rd_in = 0;
      halt_in = 0; cap_lvl = '0; peer_run = 0; err_count = 0; n_compared = 0;
      repeat (12) @(posedge clk_in);
      resetn_in <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         rd(ra[i], d);
         chk("reset value", rv[i], d);
      end
      // update, compare on channel 1, dma and interrupt
      wr(OFS_RELOAD, 32'h2);
      wr(OFS_CHMODE, 32'h18);
      wr(OFS_CCR0 + 8'h04, 32'h1);
      wr(OFS_MASK, 32'h1);
      wr(OFS_DMAEN, 32'h5);
      wr(OFS_CTRL, 32'h1);
      wait_ev(0, 1'b1, n);
      chk("update pulse", 32'h1, {31'h0, trig_out});
      chk("irq raised", 32'h1, {31'h0, irq_out});
      wait_ev(2, 1'b1, n);
      wr(OFS_CTRL, 32'h0);
      rd(OFS_STATUS, d);
      chk("status", 32'h5, d);
      chk("irq cleared", 32'h0, {31'h0, irq_out});
      wr(OFS_MASK, 32'h0);
      wr(OFS_CTRL, 32'h1);
      wait_ev(5, 1'b1, n);
      chk("irq masked", 32'h0, {31'h0, irq_out});
      // update period per mode and prescale
      for (int i = 0; i < 4; i++) begin
         wr(OFS_CTRL, 32'h0);
         wr(OFS_PRESC, pp[i]);
         wr(OFS_RELOAD, 32'h3);
         wr(OFS_COUNT, 32'h0);
         wr(OFS_CTRL, cm[i]);
         wait_ev(5, 1'b1, n);
         wait_ev(5, 1'b1, n);
         chk("update period", gp[i], n);
      end
      // step direction: frozen, up, basic forced up, down
      for (int i = 0; i < 4; i++) begin
         wr(OFS_CTRL, 32'h0);
         wr(OFS_PRESC, 32'h0);
         wr(OFS_RELOAD, 32'hFFFF);
         wr(OFS_COUNT, 32'h0);
         halt_in <= (i == 0);
         wr(OFS_CTRL, cc[i]);
         rd2(d, d2);
         chk("count step", dd[i], {16'h0, d2[15:0] - d[15:0]});
         halt_in <= 1'b0;
      end
      // one-pulse stops itself on the update
      wr(OFS_CTRL, 32'h0);
      wr(OFS_RELOAD, 32'h2);
      wr(OFS_COUNT, 32'h0);
      wr(OFS_CTRL, 32'h9);
      repeat (10) @(posedge clk_in);
      rd(OFS_CTRL, d);
      chk("one-pulse ctrl", 32'h8, d);
      // capture on rising then falling edge with the counter stopped
      wr(OFS_CTRL, 32'h0);
      for (int i = 0; i < 2; i++) begin
         wr(OFS_CHMODE, 32'h1 + i);
         wr(OFS_COUNT, i ? 32'h0BAD : 32'h1234);
         rd(OFS_STATUS, d);
         cap_lvl <= (i == 0) ? 4'h1 : 4'h0;
         repeat (10) @(posedge clk_in);
         rd(OFS_STATUS, d);
         chk("capture flag", 32'h2, d);
         rd(OFS_CCR0, d);
         chk("capture value", i ? 32'h0BAD : 32'h1234, d);
      end
      // pwm pair with dead time, then both ends of the duty range
      wr(OFS_DEAD, 32'h2);
      wr(OFS_RELOAD, 32'hF);
      wr(OFS_CHMODE, 32'h4);
      wr(OFS_CCR0, 32'h8);
      wr(OFS_COUNT, 32'h0);
      wr(OFS_CTRL, 32'h101);
      wait_ev(6, 1'b1, n);
      wait_ev(6, 1'b0, n);
      wait_ev(7, 1'b1, n);
      chk("dead gap", 32'h3, n);
      for (int i = 0; i < 2; i++) begin
         wr(OFS_CCR0, i ? 32'hFFFF : 32'h0);
         repeat (40) @(posedge clk_in);
         p = 0;
         repeat (20) begin
            @(posedge clk_in);
            #1 p += (pair_hi_out[0] === 1'b1 && pair_lo_out[0] === 1'b0);
         end
         chk("duty extreme", i ? 32'd20 : 32'd0, p);
         chk("pwm pin", i, {31'h0, pwm_out[0]});
      end
      // count peer trigger pulses instead of the prescaler
      wr(OFS_CTRL, 32'h0);
      wr(OFS_RELOAD, 32'hFFFF);
      wr(OFS_COUNT, 32'h0);
      wr(OFS_CTRL, 32'h81);
      peer_run <= 1'b1;
      p = 0;
      repeat (60) begin
         @(posedge clk_in);
         #1 p += (trig_in === 1'b1);
      end
      peer_run <= 1'b0;
      repeat (4) @(posedge clk_in);
      rd(OFS_COUNT, d);
      chk("chained count", p, d);
      // a peer pulse starts a stopped timer
      wr(OFS_CTRL, 32'h40);
      peer_run <= 1'b1;
      repeat (10) @(posedge clk_in);
      peer_run <= 1'b0;
      rd(OFS_CTRL, d);
      chk("trigger start", 32'h41, d);
      test_done();
   end
endmodule
